// file: inc/dmr_map.vh
// Command numbers, bit positions and scaling constants of the drive monitor bank
`ifndef DMR_MAP_VH
`define DMR_MAP_VH

// Monitor command numbers
`define DMR_CMD_CALC_TORQUE 8'h07
`define DMR_CMD_TORQUE_CURRENT 8'h08
`define DMR_CMD_OUTPUT_FREQUENCY 8'h09
`define DMR_CMD_MOTOR_OUTPUT_POWER 8'h0A
`define DMR_CMD_OUTPUT_CURRENT 8'h0B
`define DMR_CMD_OUTPUT_VOLTAGE 8'h0C
`define DMR_CMD_RUN_COMMAND_READBACK 8'h0D
`define DMR_CMD_DRIVE_STATUS_WORD 8'h0E
`define DMR_CMD_OUTPUT_TERMINAL_STATE 8'h0F
`define DMR_CMD_FAULT_LATEST 8'h10
`define DMR_CMD_FAULT_PREV1 8'h11
`define DMR_CMD_FAULT_PREV2 8'h12
`define DMR_CMD_FAULT_PREV3 8'h13
`define DMR_CMD_OPERATING_HOURS 8'h14
`define DMR_CMD_DC_LINK_VOLTAGE 8'h15
`define DMR_CMD_MODEL_CODE 8'h17
`define DMR_CMD_CAPACITY_CODE 8'h18
`define DMR_CMD_FIRMWARE_VERSION 8'h19
`define DMR_CMD_COMM_ERROR_CODE 8'h1A
`define DMR_CMD_CAPACITOR_LIFE 8'h2E
`define DMR_CMD_FAN_LIFE_HOURS 8'h30

// Run command readback bit positions
`define DMR_RUN_RESET 15
`define DMR_RUN_GP_IN_LO 2
`define DMR_RUN_GP_IN_W 5
`define DMR_RUN_BACKWARD 1
`define DMR_RUN_FORWARD 0

// Status word bit positions
`define DMR_ST_BUSY 15
`define DMR_ST_COMM_VALID 12
`define DMR_ST_TRIP 11
`define DMR_ST_DECEL 10
`define DMR_ST_ACCEL 9
`define DMR_ST_I_LIMIT 8
`define DMR_ST_V_LIMIT 7
`define DMR_ST_T_LIMIT 6
`define DMR_ST_DC_OK 5
`define DMR_ST_BRAKING 4
`define DMR_ST_SHUTOFF 3
`define DMR_ST_DC_BRAKE 2
`define DMR_ST_REVERSE 1
`define DMR_ST_FORWARD 0

// Output terminal bit positions
`define DMR_OUT_GP2 1
`define DMR_OUT_GP1 0

// Scaling and limits
`define DMR_RATED_FULL 16'h2710
`define DMR_HOURS_MAX 16'hFDE8
`define DMR_FAN_HOURS_MAX 16'hFFFF
`define DMR_DC_MAX_LOW 16'h01F4
`define DMR_DC_MAX_HIGH 16'h03E8
`define DMR_FW_STD_MAX 16'h0063
`define DMR_CHAR_SPACE 8'h20
`define DMR_CHAR_MINUS 8'h2D
`define DMR_NO_ALARM 16'h0000
`define DMR_ZERO16 16'h0000

`endif

// file: design/dmr_monitor_bank.v
// Read-only monitor data bank of a motor drive, read by command number
//
// Functional notes
// - Torque, torque current and output power are signed, rated quantity equals 10000.
// - Output frequency reported with 100 counts per hertz, direction carried separately.
// - Frequency answer carries a direction character: space forward/stopped, minus reverse.
// - Output current reported as ratio to rating, 100 counts per percent.
// - Run command readback: reset bit 15, inputs bits 2-6, reverse 1, forward 0.
// - Status bit 15 busy writing, bit 12 communication valid, bit 11 trip.
// - Status bit 10 decelerating, bit 9 accelerating, bit 8 current limiting.
// - Status bit 7 voltage limit, bit 6 torque limit, bit 5 DC link established.
// - Status bits 4 braking, 3 shutoff, 2 DC braking, 1 reverse, 0 forward.
// - Output terminal readback: second output bit 1, first output bit 0.
// - Four failure codes kept: current, previous, and the two before.
// - Operating time in whole hours, held within 0 to 65000.
// - DC link voltage in volts, up to 500 or 1000 by voltage class.
// - Firmware version 0 to 99 standard, above 100 non-standard.
// - Only the latest transmission error kept; cleared when power is removed.
// - Signed quantities use two's complement in the sixteen-bit word.
`timescale 1ns/10ps
`include "dmr_map.vh"

module dmr_monitor_bank #(
  parameter [15:0] MODEL_CODE = 16'h0A5A,     // Arbitrary value
  parameter [15:0] CAPACITY_CODE = 16'h0064,  // Arbitrary value
  parameter [15:0] FIRMWARE_VERSION = 16'h0001,
  parameter HIGH_VOLT_CLASS = 0
) (
  // Clock and reset
  input wire mclk,
  input wire resetn,
  // Host access
  input wire req_valid,
  input wire req_write,
  input wire [7:0] req_cmd,
  output reg rsp_valid_q,
  output reg [15:0] rsp_data_q,
  output reg rsp_has_dir_q,
  output reg [7:0] rsp_dir_char_q,
  output reg rsp_refused_q,
  // Measurements from drive logic
  input wire [15:0] torque_in,
  input wire [15:0] torque_current_in,
  input wire [15:0] out_freq_in,
  input wire [15:0] power_in,
  input wire [15:0] out_current_in,
  input wire [15:0] out_voltage_in,
  input wire [15:0] dc_link_in,
  input wire [15:0] capacitor_life_in,
  // Life counting
  input wire hour_tick,
  input wire fan_running,
  // Drive state
  input wire write_busy,
  input wire comm_valid,
  input wire trip_active,
  input wire decelerating,
  input wire accelerating,
  input wire current_limiting,
  input wire voltage_limiting,
  input wire torque_limiting,
  input wire dc_link_ok,
  input wire braking,
  input wire output_shutoff,
  input wire dc_braking,
  // Faults and communication errors
  input wire fault_strobe,
  input wire [15:0] fault_code,
  input wire comm_err_strobe,
  input wire [15:0] comm_err_code,
  // Run command from the link
  input wire [15:0] link_run_cmd,
  // Control terminal pins
  input wire forward_run,
  input wire backward_run,
  input wire reset_pin,
  input wire gp_input_1,
  input wire gp_input_2,
  input wire gp_input_3,
  input wire gp_input_4,
  input wire gp_input_5,
  // Output terminal states from drive logic
  input wire gp_output_1,
  input wire gp_output_2
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Upper clamp, used only by the DC link reading
  function [15:0] clamp_hi;
    input [15:0] val;
    input [15:0] lim;
    begin
      clamp_hi = (val > lim) ? lim : val;
    end
  endfunction

  // Magnitude of a two's complement word
  function [15:0] magnitude;
    input [15:0] val;
    begin
      magnitude = val[15] ? (~val + 16'h0001) : val;
    end
  endfunction

  // Signed clamp to plus or minus the rated figure
  // Readings beyond rating are pinned, not wrapped, so the host never sees a sign flip
  function [15:0] clamp_rated;
    input [15:0] val;
    begin
      if (!val[15] && val > `DMR_RATED_FULL)
        clamp_rated = `DMR_RATED_FULL;
      else if (val[15] && magnitude(val) > `DMR_RATED_FULL)
        clamp_rated = ~`DMR_RATED_FULL + 16'h0001;
      else
        clamp_rated = val;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Terminal pin synchronisers

  // Terminal pins come from outside the clock domain, so nothing but the
  // first flop may read them; the second flop exists only to let it settle
  localparam PIN_W = 8;
  localparam PIN_FWD = 0;
  localparam PIN_BWD = 1;
  localparam PIN_GP_LO = 2;
  localparam PIN_RST = 7;

  wire [PIN_W-1:0] pin_raw;
  reg [PIN_W-1:0] pin_meta_q;
  reg [PIN_W-1:0] pin_sync_q;
  wire fwd_pin_s;
  wire bwd_pin_s;
  wire rst_pin_s;
  wire [`DMR_RUN_GP_IN_W-1:0] gp_in_s;

  assign pin_raw = {reset_pin, gp_input_5, gp_input_4, gp_input_3,
                    gp_input_2, gp_input_1, backward_run, forward_run};

  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pin_meta_q <= {PIN_W{1'b0}};
      pin_sync_q <= {PIN_W{1'b0}};
    end else begin
      pin_meta_q <= pin_raw;
      pin_sync_q <= pin_meta_q;
    end
  end

  assign fwd_pin_s = pin_sync_q[PIN_FWD];
  assign bwd_pin_s = pin_sync_q[PIN_BWD];
  assign rst_pin_s = pin_sync_q[PIN_RST];
  assign gp_in_s = pin_sync_q[PIN_GP_LO +: `DMR_RUN_GP_IN_W];

  ////////////////////////////////////////////////////////////////////////////
  // Run command readback: link command merged with terminals

  reg [15:0] run_cmd_d;

  always @* begin
    run_cmd_d = `DMR_ZERO16;
    // Either source raises a bit; the link cannot mask a live terminal
    run_cmd_d[`DMR_RUN_FORWARD] = link_run_cmd[`DMR_RUN_FORWARD] | fwd_pin_s;
    run_cmd_d[`DMR_RUN_BACKWARD] = link_run_cmd[`DMR_RUN_BACKWARD] | bwd_pin_s;
    run_cmd_d[`DMR_RUN_GP_IN_LO +: `DMR_RUN_GP_IN_W] =
      link_run_cmd[`DMR_RUN_GP_IN_LO +: `DMR_RUN_GP_IN_W] | gp_in_s;
    run_cmd_d[`DMR_RUN_RESET] = link_run_cmd[`DMR_RUN_RESET] | rst_pin_s;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status word and terminal word

  wire freq_neg;
  wire freq_zero;
  reg [15:0] status_d;
  reg [15:0] terminal_d;

  assign freq_neg = out_freq_in[15];
  assign freq_zero = (out_freq_in == `DMR_ZERO16);

  always @* begin
    status_d = `DMR_ZERO16;
    status_d[`DMR_ST_BUSY] = write_busy;
    status_d[`DMR_ST_COMM_VALID] = comm_valid;
    status_d[`DMR_ST_TRIP] = trip_active;
    status_d[`DMR_ST_DECEL] = decelerating;
    status_d[`DMR_ST_ACCEL] = accelerating;
    status_d[`DMR_ST_I_LIMIT] = current_limiting;
    status_d[`DMR_ST_V_LIMIT] = voltage_limiting;
    status_d[`DMR_ST_T_LIMIT] = torque_limiting;
    status_d[`DMR_ST_DC_OK] = dc_link_ok;
    status_d[`DMR_ST_BRAKING] = braking;
    status_d[`DMR_ST_SHUTOFF] = output_shutoff;
    status_d[`DMR_ST_DC_BRAKE] = dc_braking;
    status_d[`DMR_ST_REVERSE] = freq_neg;
    status_d[`DMR_ST_FORWARD] = !freq_neg && !freq_zero;
    terminal_d = `DMR_ZERO16;
    terminal_d[`DMR_OUT_GP2] = gp_output_2;
    terminal_d[`DMR_OUT_GP1] = gp_output_1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Failure history and latest communication error

  reg [15:0] fault_latest_q;
  reg [15:0] fault_prev1_q;
  reg [15:0] fault_prev2_q;
  reg [15:0] fault_prev3_q;
  reg [15:0] comm_err_q;

  // Reset stands for power removal, so the error record starts empty
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      fault_latest_q <= `DMR_NO_ALARM;
      fault_prev1_q <= `DMR_NO_ALARM;
      fault_prev2_q <= `DMR_NO_ALARM;
      fault_prev3_q <= `DMR_NO_ALARM;
      comm_err_q <= `DMR_ZERO16;
    end else begin
      if (fault_strobe) begin
        fault_latest_q <= fault_code;
        fault_prev1_q <= fault_latest_q;
        fault_prev2_q <= fault_prev1_q;
        fault_prev3_q <= fault_prev2_q;
      end
      if (comm_err_strobe)
        comm_err_q <= comm_err_code;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Life counters, saturating so they never wrap back to zero

  reg [15:0] op_hours_q;
  reg [15:0] fan_hours_q;

  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      op_hours_q <= `DMR_ZERO16;
      fan_hours_q <= `DMR_ZERO16;
    end else if (hour_tick) begin
      if (op_hours_q < `DMR_HOURS_MAX)
        op_hours_q <= op_hours_q + 16'h0001;
      // Fan hours run on past the operating-hours ceiling, up to a full word
      if (fan_running && fan_hours_q != `DMR_FAN_HOURS_MAX)
        fan_hours_q <= fan_hours_q + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read decode

  wire [15:0] dc_max;
  wire [15:0] fw_word;
  reg [15:0] read_d;
  reg hit_d;
  reg dir_d;

  assign dc_max = HIGH_VOLT_CLASS ? `DMR_DC_MAX_HIGH : `DMR_DC_MAX_LOW;
  // Values above the standard range are passed as they stand
  assign fw_word = FIRMWARE_VERSION;

  // Every item is sampled at the request edge; an event in that same cycle
  // shows only in the next answer, which keeps the answer latency fixed
  always @* begin
    read_d = `DMR_ZERO16;
    hit_d = 1'b1;
    dir_d = 1'b0;
    case (req_cmd)
      `DMR_CMD_CALC_TORQUE: begin
        read_d = clamp_rated(torque_in);
      end
      `DMR_CMD_TORQUE_CURRENT: begin
        read_d = clamp_rated(torque_current_in);
      end
      `DMR_CMD_OUTPUT_FREQUENCY: begin
        read_d = magnitude(out_freq_in);
        dir_d = 1'b1;
      end
      `DMR_CMD_MOTOR_OUTPUT_POWER: begin
        read_d = clamp_rated(power_in);
      end
      `DMR_CMD_OUTPUT_CURRENT: begin
        read_d = out_current_in;
      end
      `DMR_CMD_OUTPUT_VOLTAGE: begin
        read_d = out_voltage_in;
      end
      `DMR_CMD_RUN_COMMAND_READBACK: begin
        read_d = run_cmd_d;
      end
      `DMR_CMD_DRIVE_STATUS_WORD: begin
        read_d = status_d;
      end
      `DMR_CMD_OUTPUT_TERMINAL_STATE: begin
        read_d = terminal_d;
      end
      `DMR_CMD_FAULT_LATEST: begin
        read_d = fault_latest_q;
      end
      `DMR_CMD_FAULT_PREV1: begin
        read_d = fault_prev1_q;
      end
      `DMR_CMD_FAULT_PREV2: begin
        read_d = fault_prev2_q;
      end
      `DMR_CMD_FAULT_PREV3: begin
        read_d = fault_prev3_q;
      end
      `DMR_CMD_OPERATING_HOURS: begin
        read_d = op_hours_q;
      end
      `DMR_CMD_DC_LINK_VOLTAGE: begin
        read_d = clamp_hi(dc_link_in, dc_max);
      end
      `DMR_CMD_MODEL_CODE: begin
        read_d = MODEL_CODE;
      end
      `DMR_CMD_CAPACITY_CODE: begin
        read_d = CAPACITY_CODE;
      end
      `DMR_CMD_FIRMWARE_VERSION: begin
        read_d = fw_word;
      end
      `DMR_CMD_COMM_ERROR_CODE: begin
        read_d = comm_err_q;
      end
      `DMR_CMD_CAPACITOR_LIFE: begin
        read_d = capacitor_life_in;
      end
      `DMR_CMD_FAN_LIFE_HOURS: begin
        read_d = fan_hours_q;
      end
      default: begin
        hit_d = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Answer register
  // Direction is taken from the same sample as the magnitude, so the
  // character and the number never disagree mid-reversal.

  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rsp_valid_q <= 1'b0;
      rsp_data_q <= `DMR_ZERO16;
      rsp_has_dir_q <= 1'b0;
      rsp_dir_char_q <= `DMR_CHAR_SPACE;
      rsp_refused_q <= 1'b0;
    end else begin
      rsp_valid_q <= req_valid;
      if (req_valid) begin
        if (req_write || !hit_d) begin
          // Nothing is stored on a write: every item is read-only
          rsp_data_q <= `DMR_ZERO16;
          rsp_has_dir_q <= 1'b0;
          rsp_dir_char_q <= `DMR_CHAR_SPACE;
          rsp_refused_q <= 1'b1;
        end else begin
          rsp_data_q <= read_d;
          rsp_has_dir_q <= dir_d;
          rsp_dir_char_q <= (dir_d && freq_neg) ? `DMR_CHAR_MINUS : `DMR_CHAR_SPACE;
          rsp_refused_q <= 1'b0;
        end
      end
    end
  end

endmodule // dmr_monitor_bank

// file: bench/dmr_host_model.sv
// Host controller model issuing monitor requests
`timescale 1ns/10ps
module dmr_host_model (
  // Clock
  input wire mclk,
  // Request side
  output reg req_valid,
  output reg req_write,
  output reg [7:0] req_cmd,
  // Answer side
  input wire rsp_valid_q,
  input wire [15:0] rsp_data_q,
  input wire rsp_has_dir_q,
  input wire [7:0] rsp_dir_char_q,
  input wire rsp_refused_q
);
  reg [15:0] dat;
  reg [7:0] dch;
  reg hd;
  reg rf;
  initial begin
    req_valid = 1'b0;
    req_write = 1'b0;
    req_cmd = 8'h00;
  end
  ////////////////////////////////////////////////////////////////////////
  // Gap cycles model a slow host; released lines show the inverse value
  task xfer(input reg w, input reg [7:0] c, input integer gap);
    integer i;
    begin
      @(negedge mclk);
      req_valid = 1'b1;
      req_write = w;
      req_cmd = c;
      @(negedge mclk);
      dat = rsp_valid_q ? rsp_data_q : 16'hDEAD;
      dch = rsp_dir_char_q;
      hd = rsp_has_dir_q;
      rf = rsp_refused_q;
      req_valid = 1'b0;
      req_write = ~w;
      req_cmd = ~c;
      for (i = 0; i < gap; i = i + 1) begin
        @(negedge mclk);
      end
    end
  endtask
endmodule // dmr_host_model

// file: bench/dmr_monitor_bank_sva.sv
// Port assertions of the drive monitor bank
`timescale 1ns/10ps
module dmr_monitor_bank_sva (
  // Clock and reset
  input wire mclk,
  input wire resetn,
  // Host access
  input wire req_valid,
  input wire req_write,
  input wire [7:0] req_cmd,
  input wire rsp_valid_q,
  input wire [15:0] rsp_data_q,
  input wire rsp_has_dir_q,
  input wire [7:0] rsp_dir_char_q,
  input wire rsp_refused_q,
  // Watched drive inputs
  input wire [15:0] out_freq_in,
  input wire write_busy,
  input wire comm_valid,
  input wire trip_active,
  input wire decelerating,
  input wire accelerating,
  input wire current_limiting,
  input wire gp_output_1,
  input wire gp_output_2
);
  wire rd = req_valid & ~req_write;
  wire neg = out_freq_in[15];
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////////////////
  property p_refuse;
    req_valid && req_write |=> rsp_valid_q && rsp_refused_q && rsp_data_q == 16'h0000;
  endproperty
  a_refuse: assert property (p_refuse) else $error("write not refused");
  property p_st_hi;
    rd && req_cmd == 8'h0E |=> rsp_data_q[15] == $past(write_busy)
      && rsp_data_q[12:11] == {$past(comm_valid), $past(trip_active)};
  endproperty
  a_st_hi: assert property (p_st_hi) else $error("status high bits");
  property p_st_mid;
    rd && req_cmd == 8'h0E |=> rsp_data_q[10:8]
      == {$past(decelerating), $past(accelerating), $past(current_limiting)};
  endproperty
  a_st_mid: assert property (p_st_mid) else $error("status mid bits");
  property p_dir;
    rd && req_cmd == 8'h09 |=> rsp_has_dir_q && rsp_dir_char_q == ($past(neg) ? 8'h2D : 8'h20);
  endproperty
  a_dir: assert property (p_dir) else $error("direction char");
  property p_freq;
    rd && req_cmd == 8'h09 |=> rsp_data_q
      == ($past(neg) ? 16'h0000 - $past(out_freq_in) : $past(out_freq_in));
  endproperty
  a_freq: assert property (p_freq) else $error("frequency value");
  property p_torque;
    rd && req_cmd == 8'h07 |=> $signed(rsp_data_q) <= $signed(16'h2710)
      && $signed(rsp_data_q) >= $signed(16'hD8F0);
  endproperty
  a_torque: assert property (p_torque) else $error("torque out of range");
  property p_term;
    rd && req_cmd == 8'h0F |=> rsp_data_q == {14'h0000, $past(gp_output_2), $past(gp_output_1)};
  endproperty
  a_term: assert property (p_term) else $error("terminal word");
  property p_hours;
    rd && req_cmd == 8'h14 |=> rsp_data_q <= 16'hFDE8;
  endproperty
  a_hours: assert property (p_hours) else $error("hours above limit");
endmodule // dmr_monitor_bank_sva

bind dmr_monitor_bank dmr_monitor_bank_sva u_sva (.mclk, .resetn, .req_valid, .req_write,
  .req_cmd, .rsp_valid_q, .rsp_data_q, .rsp_has_dir_q, .rsp_dir_char_q, .rsp_refused_q,
  .out_freq_in, .write_busy, .comm_valid, .trip_active, .decelerating, .accelerating,
  .current_limiting, .gp_output_1, .gp_output_2);

// file: bench/tb.sv
// Self-checking bench of the drive monitor bank
`timescale 1ns/10ps
module tb;
  localparam [15:0] FW = 16'h0063;
  localparam [15:0] MC = 16'h1357; // Arbitrary value
  localparam [15:0] CC = 16'h00C8; // Arbitrary value
  reg mclk, resetn, ht, fan, fs, es;
  reg [15:0] tq, tc, fq, pw, cu, vo, dc, cl, fc, ec, lk, le;
  reg [11:0] st;
  reg [7:0] pn;
  reg [1:0] go;
  wire req_valid, req_write, rsp_valid_q, rsp_has_dir_q, rsp_refused_q;
  wire [7:0] req_cmd, rsp_dir_char_q;
  wire [15:0] rsp_data_q;
  integer fail_count, compares, cyc, i, k, sd;
  reg [15:0] h [0:3];
  reg [15:0] tv [0:3];
  dmr_monitor_bank #(.MODEL_CODE(MC), .CAPACITY_CODE(CC), .FIRMWARE_VERSION(FW)) dut (
    .mclk, .resetn, .req_valid, .req_write,
    .req_cmd, .rsp_valid_q, .rsp_data_q, .rsp_has_dir_q, .rsp_dir_char_q, .rsp_refused_q,
    .torque_in(tq), .torque_current_in(tc), .out_freq_in(fq), .power_in(pw),
    .out_current_in(cu), .out_voltage_in(vo), .dc_link_in(dc), .capacitor_life_in(cl),
    .hour_tick(ht), .fan_running(fan), .write_busy(st[11]), .comm_valid(st[10]),
    .trip_active(st[9]), .decelerating(st[8]), .accelerating(st[7]),
    .current_limiting(st[6]), .voltage_limiting(st[5]), .torque_limiting(st[4]),
    .dc_link_ok(st[3]), .braking(st[2]), .output_shutoff(st[1]), .dc_braking(st[0]),
    .fault_strobe(fs), .fault_code(fc), .comm_err_strobe(es), .comm_err_code(ec),
    .link_run_cmd(lk), .forward_run(pn[0]), .backward_run(pn[1]), .reset_pin(pn[7]),
    .gp_input_1(pn[2]), .gp_input_2(pn[3]), .gp_input_3(pn[4]), .gp_input_4(pn[5]),
    .gp_input_5(pn[6]), .gp_output_1(go[0]), .gp_output_2(go[1]));
  dmr_host_model u_host (.mclk, .req_valid, .req_write, .req_cmd, .rsp_valid_q,
    .rsp_data_q, .rsp_has_dir_q, .rsp_dir_char_q, .rsp_refused_q);
  ////////////////////////////////////////////////////////////////////////
  function [15:0] clp(input [15:0] v);
    begin
      clp = v;
      if ($signed(v) > $signed(16'h2710)) clp = 16'h2710;
      if ($signed(v) < $signed(16'hD8F0)) clp = 16'hD8F0;
    end
  endfunction
  task chk(input [8*7:1] nm, input [16:0] s, input [16:0] e);
    begin
      compares = compares + 1;
      if (s !== e) begin
        fail_count = fail_count + 1;
        $display("MISMATCH %0s exp %h seen %h", nm, e, s);
      end
    end
  endtask
  task rdc(input [8*7:1] nm, input [7:0] c, input [15:0] e);
    begin
      u_host.xfer(1'b0, c, $urandom % 3);
      chk(nm, {1'b0, u_host.dat}, {1'b0, e});
    end
  endtask
  task give_verdict;
    begin
      $display("Comparisons %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
        $display("Run complete: PASS");
      end else begin
        $display("Run complete: FAIL");
      end
      $finish;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // Ceiling sits just above the long hour-count scenario
  always @(posedge mclk) begin
    cyc = cyc + 1;
    if (cyc == 70000) begin
      fail_count = fail_count + 1;
      give_verdict;
    end
  end
  initial begin
    {tq, tc, fq, pw, cu, vo, dc, cl, fc, ec, lk, le, st, pn, go} = 0;
    {ht, fan, fs, es} = 4'h0;
    fail_count = 0;
    compares = 0;
    cyc = 0;
    tv[0] = 16'h2711;
    tv[1] = 16'hD8EF;
    tv[2] = 16'hDEA6;
    tv[3] = 16'hD8F0;
    resetn = 1'b0;
    sd = $urandom(70130);
    repeat (10) @(posedge mclk);
    @(negedge mclk);
    resetn = 1'b1;
    for (i = 0; i < 8; i = i + 1) begin
      st = $urandom;
      pn = $urandom;
      lk = $urandom;
      go = $urandom;
      cu = $urandom;
      fq = (i == 0) ? 16'h0000 : (i == 1) ? 16'hFFFF : $urandom;
      if (fq == 16'h8000) fq = 16'h0001;
      tq = (i < 4) ? tv[i] : $urandom;
      pw = tv[(i + 1) % 4];
      tc = (i < 4) ? tv[3 - i] : $urandom;
      vo = $urandom;
      cl = $urandom;
      dc = (i < 2) ? 16'h01F5 - i : $urandom % 600;
      // Pins pass two sync flops before they show
      repeat (3) @(negedge mclk);
      rdc("status", 8'h0E, {st[11], 2'b00, st[10:0], fq[15], fq != 0 && !fq[15]});
      rdc("run", 8'h0D, (lk & 16'h807F) | {pn[7], 8'h00, pn[6:0]});
      rdc("term", 8'h0F, {14'h0000, go});
      rdc("freq", 8'h09, fq[15] ? 16'h0000 - fq : fq);
      chk("dir", {8'h00, u_host.hd, u_host.dch}, {9'h001, fq[15] ? 8'h2D : 8'h20});
      rdc("torque", 8'h07, clp(tq));
      rdc("power", 8'h0A, clp(pw));
      rdc("tqcur", 8'h08, clp(tc));
      rdc("volts", 8'h0C, vo);
      rdc("caplife", 8'h2E, cl);
      rdc("current", 8'h0B, cu);
      rdc("dclink", 8'h15, (dc > 16'h01F4) ? 16'h01F4 : dc);
    end
    for (k = 0; k < 4; k = k + 1) h[k] = 16'h0000;
    for (i = 0; i < 5; i = i + 1) begin
      fc = $urandom;
      ec = $urandom;
      fs = 1'b1;
      es = (i < 2);
      if (i == 1) le = ec;
      @(negedge mclk);
      h[3] = h[2];
      h[2] = h[1];
      h[1] = h[0];
      h[0] = fc;
    end
    {fs, es} = 2'b00;
    for (k = 0; k < 4; k = k + 1) rdc("fault", 8'h10 + k, h[k]);
    u_host.xfer(1'b1, 8'h10, 1);
    chk("refused", {u_host.rf, u_host.dat}, 17'h10000);
    chk("refdir", {8'h00, u_host.hd, u_host.dch}, {9'h000, 8'h20});
    u_host.xfer(1'b0, 8'h16, 0);
    chk("unknown", {u_host.rf, u_host.dat}, 17'h10000);
    rdc("fault", 8'h10, h[0]);
    rdc("commerr", 8'h1A, le);
    rdc("fw", 8'h19, FW);
    rdc("model", 8'h17, MC);
    rdc("capac", 8'h18, CC);
    fan = 1'b1;
    ht = 1'b1;
    @(negedge mclk);
    ht = 1'b0;
    rdc("hours", 8'h14, 16'h0001);
    // Tick every cycle to reach the ceiling in a short run
    ht = 1'b1;
    repeat (65010) @(negedge mclk);
    ht = 1'b0;
    rdc("hours", 8'h14, 16'hFDE8);
    // Fan was running for every tick and has no ceiling in reach
    rdc("fanhrs", 8'h30, 16'hFDF3);
    resetn = 1'b0;
    @(negedge mclk);
    resetn = 1'b1;
    rdc("commerr", 8'h1A, 16'h0000);
    rdc("hours", 8'h14, 16'h0000);
    rdc("fanhrs", 8'h30, 16'h0000);
    give_verdict;
  end
endmodule // tb
